// *** sfph_cfg.svh ***
`ifndef SFPH_CFG_SVH
`define SFPH_CFG_SVH
`define SFPH_OP_SLEEP 8'hB9
`define SFPH_OP_WAKE 8'hAB
`define SFPH_CLK_MHZ 50
`define SFPH_ENTRY_NS 3000
`define SFPH_EXIT_NS 8000
`define SFPH_ENTRY_CYC ((`SFPH_ENTRY_NS * `SFPH_CLK_MHZ) / 1000)
`define SFPH_EXIT_CYC ((`SFPH_EXIT_NS * `SFPH_CLK_MHZ) / 1000)
`define SFPH_CNT_W 12
`endif

// *** sfph_pkg.sv ***
package sfph_pkg;
  typedef enum logic [3:0] {
    SFPH_STANDBY = 4'h1,
    SFPH_ENTERING = 4'h2,
    SFPH_SLEEP = 4'h4,
    SFPH_EXITING = 4'h8
  } sfph_pwr_e;
endpackage : sfph_pkg

// *** sfph_sync.sv ***
`timescale 1ns/1ns
module sfph_sync (
  input wire logic clock,
  input wire logic nrst,
  input wire logic din,
  output logic dout
);
  logic meta;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : sfph_sync

// *** sfph_ctrl.sv ***
`timescale 1ns/1ns
`include "sfph_cfg.svh"
// Behaviour
// - standby when deselected and not busy
// - sleep ignores all but wake opcode
// - sleep opcode, deselect, enter after delay
// - partial or unaligned sleep command aborted
// - power-up always in standby
// - sleep command ignored while busy
// - wake opcode, deselect, standby after delay
// - partial or unaligned wake stays asleep
// - pause never stalls program or erase
// - pause starts selected, at clock low
// - paused while pause pin and select held
// - paused: output off, inputs ignored
// - pause ends at clock low
// - deselect during pause aborts, clears latch
// - launch on falling, sample on rising
module sfph_ctrl
  import sfph_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic busy,
  input wire logic latch_set,
  input wire logic tx_bit,
  output logic so,
  output logic so_oe,
  output logic write_enable_latch,
  output logic deep_sleep,
  output logic standby,
  output logic paused,
  output logic abort
);
  localparam logic [`SFPH_CNT_W-1:0] ENTRY_CYC = `SFPH_CNT_W'(`SFPH_ENTRY_CYC);
  localparam logic [`SFPH_CNT_W-1:0] EXIT_CYC = `SFPH_CNT_W'(`SFPH_EXIT_CYC);

  sfph_pwr_e state;
  logic [`SFPH_CNT_W-1:0] dcnt;

  logic [3:0] raw;
  logic [3:0] syn;
  // select and pause enter inverted so the sync reset value is their idle level
  assign raw = {~cs_n, sck, si, ~hold_n};
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      sfph_sync u_sync (
        .clock(clock),
        .nrst(nrst),
        .din(raw[g]),
        .dout(syn[g])
      );
    end
  endgenerate

  logic cs_s, sck_s, si_s, hold_s;
  assign cs_s = !syn[3];
  assign sck_s = syn[2];
  assign si_s = syn[1];
  assign hold_s = !syn[0];

  // data bit taken from the sample just before the rise
  // so a host that moves data with the rising edge is still caught
  logic sck_d, cs_d, si_d;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sck_d <= 1'b0;
      cs_d <= 1'b1;
      si_d <= 1'b0;
    end else begin
      sck_d <= sck_s;
      cs_d <= cs_s;
      si_d <= si_s;
    end
  end
  logic rise, fall, cs_rise, sel;
  assign sel = !cs_s;
  assign rise = sck_s && !sck_d;
  assign fall = !sck_s && sck_d;
  assign cs_rise = cs_s && !cs_d;

  // pause state changes only while clock is low, except that deselect clears it at any clock level
  logic next_paused;
  always_comb begin
    next_paused = paused;
    if (!sel) begin
      next_paused = 1'b0;
    end else if (!sck_s) begin
      next_paused = !hold_s;
    end
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      paused <= 1'b0;
    end else begin
      paused <= next_paused;
    end
  end

  // shifter and counter hold while paused, sample on rising
  logic [7:0] shreg;
  logic [7:0] opcode;
  logic [2:0] bitcnt;
  logic got_byte;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      shreg <= 8'h00;
      bitcnt <= 3'h0;
      got_byte <= 1'b0;
      opcode <= 8'h00;
    end else if (!sel) begin
      bitcnt <= 3'h0;
      got_byte <= 1'b0;
    end else if (rise && !paused) begin
      shreg <= {shreg[6:0], si_d};
      bitcnt <= bitcnt + 3'h1;
      if (bitcnt == 3'h7 && !got_byte) begin
        opcode <= {shreg[6:0], si_d};
        got_byte <= 1'b1;
      end
    end
  end

  logic abort_now;
  assign abort_now = cs_rise && paused;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      abort <= 1'b0;
    end else begin
      abort <= abort_now;
    end
  end

  // abort clears latch and wins over a set
  always_ff @(posedge clock) begin
    if (!nrst) begin
      write_enable_latch <= 1'b0;
    end else if (abort_now) begin
      write_enable_latch <= 1'b0;
    end else if (latch_set && state == SFPH_STANDBY) begin
      write_enable_latch <= 1'b1;
    end
  end

  // command valid only on byte boundary after full opcode
  logic aligned;
  assign aligned = got_byte && bitcnt == 3'h0 && !paused;

  // reset lands in standby; delay counts from deselect
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state <= SFPH_STANDBY;
      dcnt <= '0;
    end else begin
      unique case (state)
        SFPH_STANDBY: begin
          // sleep opcode accepted only when not busy
          if (cs_rise && aligned && opcode == `SFPH_OP_SLEEP && !busy) begin
            state <= SFPH_ENTERING;
            dcnt <= ENTRY_CYC - `SFPH_CNT_W'(1);
          end
        end
        SFPH_ENTERING: begin
          if (dcnt == '0) begin
            state <= SFPH_SLEEP;
          end else begin
            dcnt <= dcnt - `SFPH_CNT_W'(1);
          end
        end
        SFPH_SLEEP: begin
          // only the wake opcode is recognised
          if (cs_rise && aligned && opcode == `SFPH_OP_WAKE) begin
            state <= SFPH_EXITING;
            dcnt <= EXIT_CYC - `SFPH_CNT_W'(1);
          end
        end
        SFPH_EXITING: begin
          if (dcnt == '0) begin
            state <= SFPH_STANDBY;
          end else begin
            dcnt <= dcnt - `SFPH_CNT_W'(1);
          end
        end
        default: begin
          state <= SFPH_STANDBY;
        end
      endcase
    end
  end
  assign deep_sleep = state == SFPH_SLEEP;
  // standby when idle, deselected, no internal operation; busy not gated by pause
  assign standby = state == SFPH_STANDBY && !sel && !busy;

  // launch on falling edge, output off while paused or asleep
  logic drive_ok;
  assign drive_ok = sel && !paused && state == SFPH_STANDBY;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      so <= 1'b0;
    end else if (fall && drive_ok) begin
      so <= tx_bit;
    end
  end
  assign so_oe = drive_ok;

  chk_sleep_entry: assert property (@(posedge clock) disable iff (!nrst)
    state == SFPH_ENTERING && dcnt == '0 |=> state == SFPH_SLEEP)
    else $error("sleep not entered after delay");
  chk_busy_ignore: assert property (@(posedge clock) disable iff (!nrst)
    state == SFPH_STANDBY && busy |=> state != SFPH_ENTERING)
    else $error("sleep taken while busy");
  chk_wake_only: assert property (@(posedge clock) disable iff (!nrst)
    state == SFPH_SLEEP && !(cs_rise && aligned && opcode == `SFPH_OP_WAKE)
    |=> state == SFPH_SLEEP)
    else $error("sleep left without wake");
  chk_exit_done: assert property (@(posedge clock) disable iff (!nrst)
    state == SFPH_EXITING && dcnt == '0 |=> state == SFPH_STANDBY)
    else $error("exit delay not honoured");
  chk_pause_oe: assert property (@(posedge clock) disable iff (!nrst)
    paused |-> !so_oe)
    else $error("output driven while paused");
  chk_pause_clk: assert property (@(posedge clock) disable iff (!nrst)
    $rose(paused) |-> !$past(sck_s) && $past(sel))
    else $error("pause began outside clock low");
  chk_pause_hold: assert property (@(posedge clock) disable iff (!nrst)
    paused |=> $stable(bitcnt) || !sel)
    else $error("counter moved while paused");
  chk_abort_latch: assert property (@(posedge clock) disable iff (!nrst)
    abort_now |=> !write_enable_latch && abort)
    else $error("latch not cleared on abort");
  chk_unaligned: assert property (@(posedge clock) disable iff (!nrst)
    state == SFPH_STANDBY && cs_rise && bitcnt != 3'h0 |=> state == SFPH_STANDBY)
    else $error("unaligned sleep accepted");
  cov_sleep: cover property (@(posedge clock) disable iff (!nrst)
    state == SFPH_ENTERING ##[1:200] state == SFPH_SLEEP);
  cov_wake: cover property (@(posedge clock) disable iff (!nrst)
    state == SFPH_EXITING ##[1:500] state == SFPH_STANDBY);
  cov_pause: cover property (@(posedge clock) disable iff (!nrst) $fell(paused));
  cov_abort: cover property (@(posedge clock) disable iff (!nrst) abort);
endmodule : sfph_ctrl

// *** sfph_host.sv ***
`timescale 1ns/1ns
module sfph_host (
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  input wire logic so
);
  logic cap;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    cap = 1'b0;
  end
  // n bits msb first; pause after bit hb; ab drops select while paused
  task automatic frame(input logic [15:0] d, input int n, input int hb, input bit ab);
    logic [15:0] sh;
    sh = d;
    #7 cs_n = 1'b0;
    si = sh[15];
    for (int i = 0; i < n; i++) begin
      #80 sck = 1'b1;
      // next bit leaves on rising edge
      sh = sh << 1;
      si = sh[15];
      #80 sck = 1'b0;
      cap = so;
      if (i == hb) begin
        // pause pin moves only in clock-low phase, clock keeps running
        #40 hold_n = 1'b0;
        repeat (3) begin
          #40 sck = 1'b1;
          si = ~si;
          #80 sck = 1'b0;
          #40;
        end
        if (ab) begin
          cs_n = 1'b1;
          #80 hold_n = 1'b1;
          si = ~si;
          return;
        end
        hold_n = 1'b1;
        si = sh[15];
      end
    end
    #80 cs_n = 1'b1;
    // released line must not keep the last bit
    si = ~si;
    #160;
  endtask : frame
endmodule : sfph_host

// *** tb.sv ***
`timescale 1ns/1ns
`include "sfph_cfg.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
  import sfph_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic busy = 1'b0;
  logic latch_set = 1'b0;
  logic tx_bit = 1'b0;
  wire cs_n, sck, si, hold_n, so, so_oe, write_enable_latch, deep_sleep, standby, paused, abort;
  int num_errors = 0;
  int samples_checked = 0;
  int held = 0;
  int bad_oe = 0;
  int aborts = 0;
  int drove = 0;
  always #10 clock = ~clock;
  always @(posedge clock) begin
    if (so_oe === 1'b1) drove++;
    if (paused === 1'b1) held++;
    if (paused !== 1'b0 && so_oe !== 1'b0) bad_oe++;
    if (abort === 1'b1) aborts++;
  end
  sfph_host host (.cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so(so));
  sfph_ctrl DUT (.clock(clock), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .busy(busy), .latch_set(latch_set), .tx_bit(tx_bit), .so(so),
    .so_oe(so_oe), .write_enable_latch(write_enable_latch), .deep_sleep(deep_sleep),
    .standby(standby), .paused(paused), .abort(abort));
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  // target level (sleep on entry, standby on exit) absent at c-40, present by c+40
  task automatic settle(input int c, input logic e);
    cyc(c - 40);
    `CHK((e ? deep_sleep : standby), 1'b0)
    cyc(80);
    `CHK((e ? deep_sleep : standby), 1'b1)
  endtask : settle
  task automatic t_bad_sleep();
    tx_bit = 1'b1;
    host.frame(16'hB900, 5, -1, 1'b0);
    host.frame(16'hB9A0, 11, -1, 1'b0);
    `CHK(host.cap, 1'b1)
    `CHK(drove > 0, 1'b1)
    cyc(`SFPH_ENTRY_CYC + 40);
    `CHK(deep_sleep, 1'b0)
    `CHK(standby, 1'b1)
  endtask : t_bad_sleep
  task automatic t_busy();
    busy = 1'b1;
    host.frame(16'hB955, 16, -1, 1'b0);
    `CHK(standby, 1'b0)
    cyc(`SFPH_ENTRY_CYC + 40);
    `CHK(deep_sleep, 1'b0)
    busy = 1'b0;
    cyc(2);
    `CHK(standby, 1'b1)
  endtask : t_busy
  task automatic t_hold_sleep();
    held = 0;
    host.frame(16'hB900, 8, 3, 1'b0);
    settle(`SFPH_ENTRY_CYC, 1'b1);
    `CHK(held > 20, 1'b1)
    `CHK(bad_oe, 0)
    `CHK(paused, 1'b0)
    `CHK(standby, 1'b0)
  endtask : t_hold_sleep
  task automatic t_ignore();
    drove = 0;
    host.frame(16'h0500, 8, -1, 1'b0);
    host.frame(16'hAB00, 12, -1, 1'b0);
    host.frame(16'hAB00, 4, -1, 1'b0);
    cyc(`SFPH_EXIT_CYC + 40);
    `CHK(drove, 0)
    `CHK(deep_sleep, 1'b1)
    `CHK(deep_sleep, 1'b1)
  endtask : t_ignore
  task automatic t_wake();
    host.frame(16'hABFF, 16, -1, 1'b0);
    settle(`SFPH_EXIT_CYC, 1'b0);
    `CHK(standby, 1'b1)
  endtask : t_wake
  task automatic t_abort();
    latch_set = 1'b1;
    cyc(1);
    latch_set = 1'b0;
    cyc(2);
    `CHK(write_enable_latch, 1'b1)
    aborts = 0;
    host.frame(16'h0600, 8, 5, 1'b1);
    cyc(10);
    `CHK(aborts, 1)
    `CHK(write_enable_latch, 1'b0)
  endtask : t_abort
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  initial begin
    #1900000;
    num_errors++;
    summarize();
  end
  initial begin
    cyc(10);
    nrst = 1'b1;
    cyc(4);
    `CHK(standby, 1'b1)
    `CHK(deep_sleep, 1'b0)
    t_bad_sleep();
    t_busy();
    t_hold_sleep();
    t_ignore();
    t_wake();
    t_abort();
    summarize();
  end
endmodule : tb
